// file: design/acm_pkg.sv
/*
 * acm_pkg: register map, reset values, code tables and timing constants for the
 * audio clock source and monitor block.
 * assumes a 250 MHz core clock and an 8-bit register port.
 */
package acm_pkg;

    localparam logic [7:0] OFS_DETECT_STATUS = 8'h15;
    localparam logic [7:0] OFS_CLOCK_SOURCE = 8'h16;
    localparam logic [7:0] OFS_MIC_CLOCK = 8'h1f;
    localparam logic [7:0] RST_DETECT_STATUS = 8'hff;
    localparam logic [7:0] RST_CLOCK_SOURCE = 8'h10;
    localparam logic [7:0] RST_MIC_CLOCK = 8'h40;

    localparam int POS_RATE_LSB = 4;
    localparam int POS_ROOT_SEL = 7;
    localparam int POS_SPEC_MODE = 6;
    localparam int POS_RATIO_LSB = 3;
    localparam int POS_FRAME_INV = 1;
    localparam int POS_DIV_LSB = 0;

    localparam logic [3:0] CODE_INVALID = 4'hf;
    localparam int NUM_RATE_CODES = 9;
    localparam int NUM_RATIO_CODES = 13;

    localparam int CORE_CLK_HZ = 250000000;
    localparam int CORE_PERIOD_NS = 4;
    localparam int FS_TIMEOUT_NS = 160000;
    localparam int FS_TIMEOUT_CYCLES = FS_TIMEOUT_NS / CORE_PERIOD_NS;
    localparam int PERIOD_CNT_W = 18;
    localparam int BIT_CNT_W = 12;

    typedef enum logic [1:0] {ROOT_PLL, ROOT_BITCLK, ROOT_REFCLK} acm_root_e;

    typedef struct packed {
        logic master_mode;
        logic auto_config_off;
        logic auto_config_pll_off;
        logic rate_family_select;
        logic [2:0] refclk_absolute_frequency;
        logic [3:0] programmed_rate_code;
    } acm_mode_s;

    typedef struct packed {
        acm_root_e root_clock_source;
        logic frame_gen_clock_invert;
        logic [11:0] refclk_frame_ratio;
        logic [31:0] refclk_hz;
        logic [5:0] mic_clock_divide;
        logic [22:0] mic_clock_hz;
    } acm_clk_s;

    // sample rate of a paired code; family 0 is 48 kHz, 1 is 44.1 kHz
    function automatic int fs_hz(input logic [3:0] code, input logic family);
        int r48[NUM_RATE_CODES] = '{8000, 16000, 24000, 32000, 48000, 96000, 192000,
                                    384000, 768000};
        int r44[NUM_RATE_CODES] = '{7350, 14700, 22050, 29400, 44100, 88200, 176400,
                                    352800, 705600};
        fs_hz = 0;
        if (code < 4'(NUM_RATE_CODES))
            fs_hz = family ? r44[code] : r48[code];
    endfunction : fs_hz

    // widest window: 10% under the 48k period, 10% over the 44.1k period
    function automatic logic [3:0] rate_classify(input logic [PERIOD_CNT_W-1:0] period);
        int lo;
        int hi;
        rate_classify = CODE_INVALID;
        for (int i = 0; i < NUM_RATE_CODES; i++)
        begin
            lo = CORE_CLK_HZ / fs_hz(4'(i), 1'b0) * 9 / 10;
            hi = CORE_CLK_HZ / fs_hz(4'(i), 1'b1) * 11 / 10;
            if (int'(period) >= lo && int'(period) <= hi)
                rate_classify = 4'(i);
        end
    endfunction : rate_classify

    function automatic logic [3:0] ratio_classify(input logic [BIT_CNT_W-1:0] bits);
        int tab[NUM_RATIO_CODES] = '{16, 24, 32, 48, 64, 96, 128, 192, 256, 384, 512,
                                     1024, 2048};
        ratio_classify = CODE_INVALID;
        for (int i = 0; i < NUM_RATIO_CODES; i++)
            if (int'(bits) == tab[i])
                ratio_classify = 4'(i);
    endfunction : ratio_classify

    function automatic logic [11:0] refclk_ratio(input logic [2:0] code);
        logic [11:0] tab[8] = '{12'd64, 12'd256, 12'd384, 12'd512, 12'd768, 12'd1024,
                                12'd1536, 12'd2304};
        refclk_ratio = tab[code];
    endfunction : refclk_ratio

endpackage : acm_pkg

// file: design/acm_frame_detector.sv
/*
 * acm_frame_detector: measures frame sync period and bit clocks per frame,
 * publishes rate and ratio codes once two frames agree.
 * assumes bit clock and frame sync already synchronised to core_clk.
 */
`timescale 1ns/100ps
`default_nettype none

module acm_frame_detector #(
    parameter int TIMEOUT_CYCLES = acm_pkg::FS_TIMEOUT_CYCLES
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic bitclk_sync,
    input wire logic frame_sync_sync,
    output logic [3:0] detected_sample_rate_code,
    output logic [3:0] detected_bitclk_frame_ratio
);

    logic bitclk_prev, next_bitclk_prev;
    logic frame_prev, next_frame_prev;
    logic [acm_pkg::PERIOD_CNT_W-1:0] period_cnt, next_period_cnt;
    logic [acm_pkg::BIT_CNT_W-1:0] bit_cnt, next_bit_cnt;
    logic [3:0] last_rate, next_last_rate;
    logic [3:0] last_ratio, next_last_ratio;
    logic have_last, next_have_last;
    logic [3:0] next_rate, next_ratio;
    logic bit_rise, frame_rise, timed_out;
    logic [3:0] meas_rate, meas_ratio;

    assign bit_rise = bitclk_sync & ~bitclk_prev;
    assign frame_rise = frame_sync_sync & ~frame_prev;
    assign timed_out = period_cnt >= acm_pkg::PERIOD_CNT_W'(TIMEOUT_CYCLES);
    assign meas_rate = acm_pkg::rate_classify(period_cnt + 1'b1);
    assign meas_ratio = acm_pkg::ratio_classify(bit_cnt);

    always_comb
    begin
        next_bitclk_prev = bitclk_sync;
        next_frame_prev = frame_sync_sync;
        next_period_cnt = timed_out ? period_cnt : period_cnt + 1'b1;
        next_bit_cnt = (bit_rise && bit_cnt != '1) ? bit_cnt + 1'b1 : bit_cnt;
        next_last_rate = last_rate;
        next_last_ratio = last_ratio;
        next_have_last = have_last;
        next_rate = detected_sample_rate_code;
        next_ratio = detected_bitclk_frame_ratio;
        if (frame_rise)
        begin
            // two equal frames in a row before publishing
            if (have_last && meas_rate == last_rate && meas_ratio == last_ratio)
            begin
                next_rate = meas_rate;
                next_ratio = meas_ratio;
            end
            next_last_rate = meas_rate;
            next_last_ratio = meas_ratio;
            next_have_last = 1'b1;
            next_period_cnt = '0;
            next_bit_cnt = bit_rise ? acm_pkg::BIT_CNT_W'(1) : '0;
        end
        else if (timed_out)
        begin
            // clocks stopped: back to invalid
            next_rate = acm_pkg::CODE_INVALID;
            next_ratio = acm_pkg::CODE_INVALID;
            next_have_last = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bitclk_prev <= 1'b0;
            frame_prev <= 1'b0;
            period_cnt <= '0;
            bit_cnt <= '0;
            last_rate <= acm_pkg::CODE_INVALID;
            last_ratio <= acm_pkg::CODE_INVALID;
            have_last <= 1'b0;
            detected_sample_rate_code <= acm_pkg::CODE_INVALID;
            detected_bitclk_frame_ratio <= acm_pkg::CODE_INVALID;
        end
        else
        begin
            bitclk_prev <= next_bitclk_prev;
            frame_prev <= next_frame_prev;
            period_cnt <= next_period_cnt;
            bit_cnt <= next_bit_cnt;
            last_rate <= next_last_rate;
            last_ratio <= next_last_ratio;
            have_last <= next_have_last;
            detected_sample_rate_code <= next_rate;
            detected_bitclk_frame_ratio <= next_ratio;
        end
    end

    sequence frame_seen_s;
        frame_rise && !timed_out;
    endsequence

    status_needs_frame_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (detected_sample_rate_code != $past(detected_sample_rate_code) &&
         detected_sample_rate_code != acm_pkg::CODE_INVALID) |-> $past(frame_rise))
        else $error("rate code changed without a frame edge");

    timeout_invalid_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (timed_out && !frame_rise) |=> detected_sample_rate_code == acm_pkg::CODE_INVALID
        && detected_bitclk_frame_ratio == acm_pkg::CODE_INVALID)
        else $error("status not invalid after timeout");

    rate_code_range_a: assert property (@(posedge core_clk) disable iff (!resetn)
        detected_sample_rate_code <= 4'h8 || detected_sample_rate_code == 4'hf)
        else $error("rate code in reserved range");

    ratio_code_range_a: assert property (@(posedge core_clk) disable iff (!resetn)
        detected_bitclk_frame_ratio <= 4'hc || detected_bitclk_frame_ratio == 4'hf)
        else $error("ratio code in reserved range");

    period_restart_a: assert property (@(posedge core_clk) disable iff (!resetn)
        frame_seen_s |=> period_cnt == '0)
        else $error("period counter not restarted by frame");

endmodule : acm_frame_detector

`default_nettype wire

// file: design/acm_clock_control.sv
/*
 * acm_clock_control: audio clock source selection, reference clock spec,
 * mic clock divider and serial bus clock monitor with register access.
 * assumes a one-cycle register port from the control interface decoder and
 * mode bits coming from the neighbouring master configuration register.
 */
`timescale 1ns/100ps
`default_nettype none

module acm_clock_control #(
    parameter int TIMEOUT_CYCLES = acm_pkg::FS_TIMEOUT_CYCLES
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic bitclk_pin,
    input wire logic frame_sync_pin,
    input wire acm_pkg::acm_mode_s mode,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata,
    output acm_pkg::acm_clk_s clk_cfg
);

    logic [1:0] bitclk_meta;
    logic [1:0] frame_meta;
    logic [7:0] clock_source_cfg, next_clock_source_cfg;
    logic [7:0] mic_clock_cfg, next_mic_clock_cfg;
    logic [7:0] next_reg_rdata;
    logic [3:0] detected_sample_rate_code;
    logic [3:0] detected_bitclk_frame_ratio;
    logic [7:0] detect_status;
    acm_pkg::acm_clk_s next_clk_cfg;
    logic root_clock_source_select;
    logic refclk_frequency_spec_mode;
    logic [2:0] ratio_sel;
    logic [1:0] mic_clock_divider;
    logic [3:0] fs_code;

    // pins are asynchronous; only the second stage is read
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bitclk_meta <= 2'h0;
            frame_meta <= 2'h0;
        end
        else
        begin
            bitclk_meta <= {bitclk_meta[0], bitclk_pin};
            frame_meta <= {frame_meta[0], frame_sync_pin};
        end
    end

    acm_frame_detector #(
        .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
    ) u_detector (
        .core_clk(core_clk),
        .resetn(resetn),
        .bitclk_sync(bitclk_meta[1]),
        .frame_sync_sync(frame_meta[1]),
        .detected_sample_rate_code(detected_sample_rate_code),
        .detected_bitclk_frame_ratio(detected_bitclk_frame_ratio)
    );

    assign detect_status = {detected_sample_rate_code,
        detected_bitclk_frame_ratio};
    assign root_clock_source_select = clock_source_cfg[acm_pkg::POS_ROOT_SEL];
    assign refclk_frequency_spec_mode = clock_source_cfg[acm_pkg::POS_SPEC_MODE];
    assign ratio_sel = clock_source_cfg[acm_pkg::POS_RATIO_LSB +: 3];
    assign mic_clock_divider = mic_clock_cfg[acm_pkg::POS_DIV_LSB +: 2];
    // slave rate comes from the bus itself, master rate from its own setting
    assign fs_code = mode.master_mode ? mode.programmed_rate_code : detected_sample_rate_code;

    function automatic logic [31:0] abs_refclk_hz(input logic [2:0] code);
        logic [31:0] tab[8] = '{32'd12000000, 32'd12288000, 32'd13000000, 32'd16000000,
                                32'd19200000, 32'd19680000, 32'd24000000, 32'd24576000};
        abs_refclk_hz = tab[code];
    endfunction : abs_refclk_hz

    // register writes: reserved bits are stored as written, host keeps them
    always_comb
    begin
        next_clock_source_cfg = clock_source_cfg;
        next_mic_clock_cfg = mic_clock_cfg;
        next_reg_rdata = reg_rdata;
        if (reg_wr_en)
        begin
            unique case (reg_addr)
                acm_pkg::OFS_CLOCK_SOURCE: next_clock_source_cfg = reg_wdata;
                acm_pkg::OFS_MIC_CLOCK: next_mic_clock_cfg = reg_wdata;
                default: next_clock_source_cfg = clock_source_cfg;
            endcase
        end
        if (reg_rd_en)
        begin
            unique case (reg_addr)
                acm_pkg::OFS_DETECT_STATUS: next_reg_rdata = detect_status;
                acm_pkg::OFS_CLOCK_SOURCE: next_reg_rdata = clock_source_cfg;
                acm_pkg::OFS_MIC_CLOCK: next_reg_rdata = mic_clock_cfg;
                default: next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_comb
    begin
        next_clk_cfg = clk_cfg;
        // root choice only applies to automatic slave with the pll off
        if (!mode.master_mode && !mode.auto_config_off && mode.auto_config_pll_off)
            next_clk_cfg.root_clock_source = root_clock_source_select ?
                acm_pkg::ROOT_REFCLK : acm_pkg::ROOT_BITCLK;
        else
            next_clk_cfg.root_clock_source = acm_pkg::ROOT_PLL;
        next_clk_cfg.frame_gen_clock_invert = mode.master_mode &
            clock_source_cfg[acm_pkg::POS_FRAME_INV];
        next_clk_cfg.refclk_frame_ratio = acm_pkg::refclk_ratio(ratio_sel);
        if (refclk_frequency_spec_mode)
            next_clk_cfg.refclk_hz = 32'(next_clk_cfg.refclk_frame_ratio *
                acm_pkg::fs_hz(fs_code, mode.rate_family_select));
        else
            next_clk_cfg.refclk_hz = abs_refclk_hz(mode.refclk_absolute_frequency);
        // mic clock from a 24.576/22.5792 MHz base; code 3 divides by 4 for the top rate
        unique case (mic_clock_divider)
            2'h0: next_clk_cfg.mic_clock_divide = 6'h08;
            2'h1: next_clk_cfg.mic_clock_divide = 6'h10;
            2'h2: next_clk_cfg.mic_clock_divide = 6'h20;
            2'h3: next_clk_cfg.mic_clock_divide = 6'h04;
        endcase
        next_clk_cfg.mic_clock_hz = 23'((mode.rate_family_select ? 32'd22579200 : 32'd24576000)
            / {26'h0, next_clk_cfg.mic_clock_divide});
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            clock_source_cfg <= acm_pkg::RST_CLOCK_SOURCE;
            mic_clock_cfg <= acm_pkg::RST_MIC_CLOCK;
            reg_rdata <= 8'h00;
            clk_cfg <= '0;
        end
        else
        begin
            clock_source_cfg <= next_clock_source_cfg;
            mic_clock_cfg <= next_mic_clock_cfg;
            reg_rdata <= next_reg_rdata;
            clk_cfg <= next_clk_cfg;
        end
    end

    sequence status_read_s;
        reg_rd_en && reg_addr == acm_pkg::OFS_DETECT_STATUS;
    endsequence

    status_readback_a: assert property (@(posedge core_clk) disable iff (!resetn)
        status_read_s |=> reg_rdata == $past(detect_status))
        else $error("status read does not return detector codes");

    root_select_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (!mode.master_mode && !mode.auto_config_off && mode.auto_config_pll_off
         && root_clock_source_select) |=> clk_cfg.root_clock_source == acm_pkg::ROOT_REFCLK)
        else $error("refclk root not selected");

    root_bitclk_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (!mode.master_mode && !mode.auto_config_off && mode.auto_config_pll_off
         && !root_clock_source_select) |=> clk_cfg.root_clock_source == acm_pkg::ROOT_BITCLK)
        else $error("bit clock root not selected");

    pll_root_a: assert property (@(posedge core_clk) disable iff (!resetn)
        mode.master_mode |=> clk_cfg.root_clock_source == acm_pkg::ROOT_PLL)
        else $error("root not pll in master mode");

    auto_off_root_a: assert property (@(posedge core_clk) disable iff (!resetn)
        mode.auto_config_off |=> clk_cfg.root_clock_source == acm_pkg::ROOT_PLL)
        else $error("root not pll with automatic configuration off");

    spec_abs_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (!refclk_frequency_spec_mode && mode.refclk_absolute_frequency == 3'h7)
        |=> clk_cfg.refclk_hz == 32'd24576000)
        else $error("absolute refclk frequency wrong");

    // 384 times 48 kHz in master mode
    spec_ratio_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (refclk_frequency_spec_mode && mode.master_mode && !mode.rate_family_select
         && mode.programmed_rate_code == 4'h4 && ratio_sel == 3'h2)
        |=> clk_cfg.refclk_hz == 32'h01194000)
        else $error("ratio refclk frequency wrong");

    ratio_map_a: assert property (@(posedge core_clk) disable iff (!resetn)
        ratio_sel == 3'h7 |=> clk_cfg.refclk_frame_ratio == 12'd2304)
        else $error("refclk ratio wrong");

    sequence source_write_s;
        reg_wr_en && reg_addr == acm_pkg::OFS_CLOCK_SOURCE;
    endsequence

    source_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
        source_write_s |=> clock_source_cfg == $past(reg_wdata))
        else $error("clock source write did not land");

    frame_invert_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !mode.master_mode |=> !clk_cfg.frame_gen_clock_invert)
        else $error("frame invert outside master mode");

    mic_clock_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (mic_clock_divider == 2'h3 && !mode.rate_family_select)
        |=> clk_cfg.mic_clock_hz == 23'd6144000)
        else $error("mic clock top rate wrong");

    // 5.6448 MHz for the 44.1k family
    mic_family_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (mic_clock_divider == 2'h3 && mode.rate_family_select)
        |=> clk_cfg.mic_clock_hz == 23'h562200)
        else $error("mic clock top rate wrong for 44.1k family");

endmodule : acm_clock_control

`default_nettype wire

// file: tb/acm_host_model.sv
/*
 * acm_host_model: host side of the audio serial port, drives bit clock and frame sync.
 * assumes the bench sets bits and half_ns before raising run.
 */
`timescale 1ns/100ps
`default_nettype none

module acm_host_model (
    input wire logic run,
    input var int bits,
    input var real half_ns,
    output logic bitclk,
    output logic frame_sync
);
    initial
    begin
        bitclk = 1'b0;
        frame_sync = 1'b0;
    end

    // whole frames only; both lines stand still low between bursts
    always
    begin
        wait (run);
        for (int i = 0; i < bits; i++)
        begin
            bitclk = 1'b0;
            frame_sync = (i == 0);
            #(half_ns);
            bitclk = 1'b1;
            #(half_ns);
        end
        bitclk = 1'b0;
        frame_sync = 1'b0;
    end
endmodule : acm_host_model

`default_nettype wire

// file: tb/acm_clock_control_test.sv
/*
 * acm_clock_control_test: register, clock config and detector scenarios.
 * assumes acm_host_model as the serial bus host; shortened detector timeout.
 */
`timescale 1ns/100ps
`default_nettype none

module acm_clock_control_test;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic bitclk_pin;
    logic frame_sync_pin;
    acm_pkg::acm_mode_s mode = '0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr_en = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_rdata;
    acm_pkg::acm_clk_s clk_cfg;
    logic run = 1'b0;
    int bits = 64;
    // half periods chosen so pin edges never land on a rising core clock edge
    real half_ns = 40.8;
    int n_fail = 0;
    int n_tests = 0;

    always #2 core_clk = ~core_clk;

    // short timeout keeps the idle check brief; only fast rates are used
    acm_clock_control #(.TIMEOUT_CYCLES(2000)) u_dut (.core_clk(core_clk), .resetn(resetn),
        .bitclk_pin(bitclk_pin), .frame_sync_pin(frame_sync_pin), .mode(mode),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
        .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .clk_cfg(clk_cfg));

    acm_host_model u_host (.run(run), .bits(bits), .half_ns(half_ns), .bitclk(bitclk_pin),
        .frame_sync(frame_sync_pin));

    task automatic conclude();
        if (n_fail == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : chk

    // entered at a falling edge; returns once clk_cfg has caught up
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge core_clk);
        reg_wr_en = 1'b0;
        @(negedge core_clk);
        @(negedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge core_clk);
        reg_rd_en = 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask : rd

    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(what, 32'(exp), 32'(d));
    endtask : rchk

    task automatic settle();
        @(negedge core_clk);
        @(negedge core_clk);
    endtask : settle

    // bounded poll; running out counts once and ends the run
    task automatic poll(input logic [7:0] exp);
        logic [7:0] d;
        d = ~exp;
        for (int k = 0; k < 4000 && d !== exp; k++)
            rd(8'h15, d);
        chk("detect_status", 32'(exp), 32'(d));
        if (d !== exp)
            conclude();
    endtask : poll

    task automatic t_reset();
        rchk("detect_status", 8'h15, 8'hff);
        rchk("clock_source", 8'h16, 8'h10);
        rchk("mic_clock", 8'h1f, 8'h40);
        chk("refclk_ratio", 32'd384, 32'(clk_cfg.refclk_frame_ratio));
        chk("mic_divide", 32'd8, 32'(clk_cfg.mic_clock_divide));
        chk("root", 32'(acm_pkg::ROOT_PLL), 32'(clk_cfg.root_clock_source));
    endtask : t_reset

    task automatic t_source();
        mode.auto_config_pll_off = 1'b1;
        wr(8'h16, 8'h00);
        chk("root", 32'(acm_pkg::ROOT_BITCLK), 32'(clk_cfg.root_clock_source));
        wr(8'h16, 8'h80);
        chk("root", 32'(acm_pkg::ROOT_REFCLK), 32'(clk_cfg.root_clock_source));
        rchk("clock_source", 8'h16, 8'h80);
        mode.auto_config_off = 1'b1;
        settle();
        chk("root", 32'(acm_pkg::ROOT_PLL), 32'(clk_cfg.root_clock_source));
        mode.auto_config_off = 1'b0;
        mode.auto_config_pll_off = 1'b0;
        settle();
        chk("root", 32'(acm_pkg::ROOT_PLL), 32'(clk_cfg.root_clock_source));
        wr(8'h15, 8'h00);
        rchk("detect_status", 8'h15, 8'hff);
        rchk("unmapped", 8'h17, 8'h00);
    endtask : t_source

    task automatic t_refclk();
        int rt[8] = '{64, 256, 384, 512, 768, 1024, 1536, 2304};
        int ab[8] = '{12000000, 12288000, 13000000, 16000000, 19200000, 19680000,
                      24000000, 24576000};
        for (int c = 0; c < 8; c++)
        begin
            mode.refclk_absolute_frequency = 3'(c);
            wr(8'h16, {2'b00, 3'(c), 3'b000});
            chk("refclk_ratio", 32'(rt[c]), 32'(clk_cfg.refclk_frame_ratio));
            chk("refclk_hz", 32'(ab[c]), clk_cfg.refclk_hz);
        end
        mode.master_mode = 1'b1;
        mode.programmed_rate_code = 4'h4;
        wr(8'h16, 8'h50);
        chk("refclk_hz", 32'd18432000, clk_cfg.refclk_hz);
        mode.rate_family_select = 1'b1;
        settle();
        chk("refclk_hz", 32'd16934400, clk_cfg.refclk_hz);
        wr(8'h16, 8'h52);
        chk("frame_invert", 32'd1, 32'(clk_cfg.frame_gen_clock_invert));
        mode.master_mode = 1'b0;
        settle();
        chk("frame_invert", 32'd0, 32'(clk_cfg.frame_gen_clock_invert));
    endtask : t_refclk

    task automatic t_mic();
        int dv[4] = '{8, 16, 32, 4};
        int base;
        // top rate used as if only channels 1 and 2 were active
        for (int f = 0; f < 2; f++)
            for (int c = 0; c < 4; c++)
            begin
                mode.rate_family_select = f[0];
                base = f ? 22579200 : 24576000;
                wr(8'h1f, 8'h40 | 8'(c));
                chk("mic_divide", 32'(dv[c]), 32'(clk_cfg.mic_clock_divide));
                chk("mic_hz", 32'(base / dv[c]), 32'(clk_cfg.mic_clock_hz));
            end
        rchk("mic_clock", 8'h1f, 8'h43);
    endtask : t_mic

    task automatic t_detect();
        bits = 64;
        half_ns = 40.8;
        run = 1'b1;
        poll(8'h64);
        // slave ratio spec follows the detected rate: 384 x 176.4 kHz
        chk("refclk_hz", 32'h04099800, clk_cfg.refclk_hz);
        bits = 32;
        poll(8'h72);
        bits = 40;
        half_ns = 65.6;
        poll(8'h6f);
        run = 1'b0;
        poll(8'hff);
        chk("refclk_hz", 32'h00000000, clk_cfg.refclk_hz);
    endtask : t_detect

    initial
    begin
        repeat (20) @(negedge core_clk);
        resetn = 1'b1;
        @(negedge core_clk);
        t_reset();
        t_source();
        t_refclk();
        t_mic();
        t_detect();
        conclude();
    end
endmodule : acm_clock_control_test

`default_nettype wire
